// ===== rtl/acc_regs.svh
// register offsets, reset values and field positions of the channel configuration bank
// assumes it is included by its bare name from the package and the bank module
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

`define ACC_OFS_CH1_VOLUME       8'h3e
`define ACC_OFS_CH1_GAIN_TRIM    8'h3f
`define ACC_OFS_CH1_PHASE_TRIM   8'h40
`define ACC_OFS_CH2_INPUT_SETUP  8'h41
`define ACC_OFS_SECOND_CHANNEL_GAIN_CODE_SETTING 8'h42

`define ACC_RST_CH1_VOLUME       8'hc9
`define ACC_RST_CH1_GAIN_TRIM    8'h80
`define ACC_RST_CH1_PHASE_TRIM   8'h00
`define ACC_RST_CH2_INPUT_SETUP  8'h00
`define ACC_RST_SECOND_CHANNEL_GAIN_CODE_SETTING 8'h00

`define ACC_VOL_MUTE_CODE        8'h00
`define ACC_VOL_UNITY_CODE       9'h0c9
`define ACC_TRIM_MSB             7
`define ACC_TRIM_LSB             4
`define ACC_TRIM_UNITY_CODE      5'h08
`define ACC_TRIM_WMASK           8'hf0

`define ACC_IN_TYPE_BIT          7
`define ACC_IN_SRC_MSB           6
`define ACC_IN_SRC_LSB           5
`define ACC_IN_COUPLE_BIT        4
`define ACC_IN_IMP_MSB           3
`define ACC_IN_IMP_LSB           2
`define ACC_IN_AGC_BIT           0
`define ACC_IN_WMASK             8'hfd

`define ACC_GAIN_MSB             7
`define ACC_GAIN_LSB             1
`define ACC_GAIN_NEG_BIT         0
`define ACC_GAIN_MAX_CODE        7'h54
`define ACC_GAIN_NEG_MAX_CODE    7'h16

`define ACC_PHASE_DEPTH          256

`endif

// ===== rtl/acc_pkg.sv
// types of the channel configuration bank
// assumes acc_regs.svh is on the include path
`include "acc_regs.svh"

package acc_pkg;

  typedef enum logic [1:0] {
    ACC_SRC_ANA_DIFF = 2'h0,
    ACC_SRC_ANA_SE   = 2'h1,
    ACC_SRC_PDM      = 2'h2,
    ACC_SRC_RSVD     = 2'h3
  } acc_src_e;

  typedef enum logic [1:0] {
    ACC_IMP_2K5  = 2'h0,
    ACC_IMP_10K  = 2'h1,
    ACC_IMP_20K  = 2'h2,
    ACC_IMP_RSVD = 2'h3
  } acc_imp_e;

  typedef logic [`ACC_PHASE_DEPTH-1:0] acc_delay_t;

  typedef struct packed {
    logic [7:0]      ch1_volume;
    logic [7:0]      ch1_gain_trim;
    logic [7:0]      ch1_phase_trim;
    logic [7:0]      ch2_input_setup;
    logic [7:0]      second_channel_gain_code_setting;
    logic [7:0]      rdata;
    logic            rvalid;
    acc_delay_t      delay_line;
    logic            delayed_bit;
    logic            ch1_mute;
    logic [8:0]      ch1_volume_half_db;
    logic [4:0]      ch1_trim_tenth_db;
    logic            ch2_line_input;
    acc_src_e        ch2_source;
    logic            second_channel_coupling;
    acc_imp_e        ch2_impedance;
    logic            ch2_agc_enable;
    logic [6:0]      second_channel_gain_code_half_db;
    logic            second_channel_gain_code_negative;
    logic            ch2_setup_reserved;
  } acc_state_s;

endpackage : acc_pkg

// ===== rtl/acc_bank.sv
// channel configuration register bank: storage, readback and decoded settings
// assumes a single-clock register port driven by the control-port logic on sys_clk,
// and a modulator sample strobe from logic on the same clock
`include "acc_regs.svh"

module acc_bank
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // register port
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // channel one modulator stream
  input  wire logic       mod_tick,
  input  wire logic       mod_bit,
  output logic            ch1_delayed_bit,
  // channel one decoded settings
  output logic            ch1_mute,
  output logic      [8:0] ch1_volume_half_db,
  output logic      [4:0] ch1_trim_tenth_db,
  output logic      [7:0] ch1_phase_cycles,
  // channel two decoded settings
  output logic            ch2_line_input,
  output logic      [1:0] ch2_source,
  output logic            second_channel_coupling,
  output logic      [1:0] ch2_impedance,
  output logic            ch2_agc_enable,
  output logic      [6:0] second_channel_gain_code_half_db,
  output logic            second_channel_gain_code_negative,
  output logic            ch2_setup_reserved
);

  logic       rst_meta_q;
  logic       rst_sync_q;
  acc_state_s st_q;
  acc_state_s st_d;

  // reset released through two flops so release is clean on sys_clk
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  localparam acc_state_s RST_STATE = '{
    ch1_volume:         `ACC_RST_CH1_VOLUME,
    ch1_gain_trim:      `ACC_RST_CH1_GAIN_TRIM,
    ch1_phase_trim:     `ACC_RST_CH1_PHASE_TRIM,
    ch2_input_setup:    `ACC_RST_CH2_INPUT_SETUP,
    second_channel_gain_code_setting:   `ACC_RST_SECOND_CHANNEL_GAIN_CODE_SETTING,
    rdata:              8'h00,
    rvalid:             1'b0,
    delay_line:         '0,
    delayed_bit:        1'b0,
    ch1_mute:           1'b0,
    ch1_volume_half_db: 9'h000,
    ch1_trim_tenth_db:  5'h00,
    ch2_line_input:     1'b0,
    ch2_source:         ACC_SRC_ANA_DIFF,
    second_channel_coupling: 1'b0,
    ch2_impedance:      ACC_IMP_2K5,
    ch2_agc_enable:     1'b0,
    second_channel_gain_code_half_db:   7'h00,
    second_channel_gain_code_negative:  1'b0,
    ch2_setup_reserved: 1'b0
  };

  always_comb begin
    logic [7:0] vol;
    logic [7:0] setup;
    logic [7:0] gain;
    logic [6:0] gmag;
    logic       neg_ok;
    st_d   = st_q;
    vol    = 8'h00;
    setup  = 8'h00;
    gain   = 8'h00;
    gmag   = 7'h00;
    neg_ok = 1'b0;

    // register writes; unmapped offsets are ignored
    if (reg_wr_en) begin
      case (reg_addr)
        `ACC_OFS_CH1_VOLUME:       st_d.ch1_volume = reg_wdata;
        `ACC_OFS_CH1_GAIN_TRIM:    st_d.ch1_gain_trim = reg_wdata & `ACC_TRIM_WMASK;
        `ACC_OFS_CH1_PHASE_TRIM:   st_d.ch1_phase_trim = reg_wdata;
        `ACC_OFS_CH2_INPUT_SETUP:  st_d.ch2_input_setup = reg_wdata & `ACC_IN_WMASK;
        `ACC_OFS_SECOND_CHANNEL_GAIN_CODE_SETTING: st_d.second_channel_gain_code_setting = reg_wdata;
        default:                   st_d.ch1_volume = st_q.ch1_volume;
      endcase
    end

    // readback one cycle after the strobe; unmapped offsets read zero
    st_d.rvalid = reg_rd_en;
    st_d.rdata  = 8'h00;
    if (reg_rd_en) begin
      case (reg_addr)
        `ACC_OFS_CH1_VOLUME:       st_d.rdata = st_q.ch1_volume;
        `ACC_OFS_CH1_GAIN_TRIM:    st_d.rdata = st_q.ch1_gain_trim;
        `ACC_OFS_CH1_PHASE_TRIM:   st_d.rdata = st_q.ch1_phase_trim;
        `ACC_OFS_CH2_INPUT_SETUP:  st_d.rdata = st_q.ch2_input_setup;
        `ACC_OFS_SECOND_CHANNEL_GAIN_CODE_SETTING: st_d.rdata = st_q.second_channel_gain_code_setting;
        default:                   st_d.rdata = 8'h00;
      endcase
    end

    // decode from the stored values, so outputs follow a write by two cycles
    vol   = st_q.ch1_volume;
    setup = st_q.ch2_input_setup;
    gain  = st_q.second_channel_gain_code_setting;

    st_d.ch1_mute = (vol == `ACC_VOL_MUTE_CODE);
    // signed half-dB: code 1 -> -200, 201 -> 0, 255 -> +54
    st_d.ch1_volume_half_db = {1'b0, vol} - `ACC_VOL_UNITY_CODE;
    // signed tenth-dB: code 0 -> -8, 8 -> 0, 15 -> +7
    st_d.ch1_trim_tenth_db = {1'b0, st_q.ch1_gain_trim[`ACC_TRIM_MSB:`ACC_TRIM_LSB]}
                             - `ACC_TRIM_UNITY_CODE;

    st_d.ch2_line_input = setup[`ACC_IN_TYPE_BIT];
    st_d.ch2_source     = acc_src_e'(setup[`ACC_IN_SRC_MSB:`ACC_IN_SRC_LSB]);
    st_d.ch2_impedance  = acc_imp_e'(setup[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB]);
    // coupling is forced off only on the pdm path
    st_d.second_channel_coupling = setup[`ACC_IN_COUPLE_BIT] &&
      (setup[`ACC_IN_SRC_MSB:`ACC_IN_SRC_LSB] != ACC_SRC_PDM);
    st_d.ch2_agc_enable = setup[`ACC_IN_AGC_BIT];
    // reserved codes are stored as written but flagged for the analog front end
    st_d.ch2_setup_reserved =
      (setup[`ACC_IN_SRC_MSB:`ACC_IN_SRC_LSB] == ACC_SRC_RSVD) ||
      (setup[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB] == ACC_IMP_RSVD);

    // negative gain needs the 10k or 20k input network
    neg_ok = gain[`ACC_GAIN_NEG_BIT] &&
             ((setup[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB] == ACC_IMP_10K) ||
              (setup[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB] == ACC_IMP_20K));
    gmag = gain[`ACC_GAIN_MSB:`ACC_GAIN_LSB];
    // reserved codes above 42 dB saturate rather than wrap the analog stage
    if (gmag > `ACC_GAIN_MAX_CODE) begin
      gmag = `ACC_GAIN_MAX_CODE;
    end
    if (neg_ok && (gmag > `ACC_GAIN_NEG_MAX_CODE)) begin
      gmag = `ACC_GAIN_NEG_MAX_CODE;
    end
    st_d.second_channel_gain_code_half_db  = gmag;
    st_d.second_channel_gain_code_negative = neg_ok;

    // phase trim: tap N of a shift line advanced once per modulator cycle
    if (mod_tick) begin
      st_d.delay_line = {st_q.delay_line[`ACC_PHASE_DEPTH-2:0], mod_bit};
      if (st_q.ch1_phase_trim == 8'h00) begin
        st_d.delayed_bit = mod_bit;
      end else begin
        st_d.delayed_bit = st_q.delay_line[st_q.ch1_phase_trim - 8'h01];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q <= RST_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata          = st_q.rdata;
  assign reg_rvalid         = st_q.rvalid;
  assign ch1_delayed_bit    = st_q.delayed_bit;
  assign ch1_mute           = st_q.ch1_mute;
  assign ch1_volume_half_db = st_q.ch1_volume_half_db;
  assign ch1_trim_tenth_db  = st_q.ch1_trim_tenth_db;
  assign ch1_phase_cycles   = st_q.ch1_phase_trim;
  assign ch2_line_input     = st_q.ch2_line_input;
  assign ch2_source         = st_q.ch2_source;
  assign second_channel_coupling = st_q.second_channel_coupling;
  assign ch2_impedance      = st_q.ch2_impedance;
  assign ch2_agc_enable     = st_q.ch2_agc_enable;
  assign second_channel_gain_code_half_db   = st_q.second_channel_gain_code_half_db;
  assign second_channel_gain_code_negative  = st_q.second_channel_gain_code_negative;
  assign ch2_setup_reserved = st_q.ch2_setup_reserved;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_q);

  a_vol_reset_value: assert property (
    $rose(rst_sync_q) |-> st_q.ch1_volume == `ACC_RST_CH1_VOLUME)
    else $error("volume register left reset with wrong value");

  a_mute_on_zero: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'h00
    |-> ##2 ch1_mute)
    else $error("zero volume code did not mute");

  a_vol_step_map: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'h01
    |-> ##2 ch1_volume_half_db == 9'h138)
    else $error("volume code one not at -100 dB");

  a_vol_unity_map: assert property (
    ch1_volume_half_db == 9'h000 |-> $past(st_q.ch1_volume) == 8'hc9)
    else $error("unity volume from a code other than 201");

  a_vol_top_map: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'hff
    |-> ##2 ch1_volume_half_db == 9'h036 && !ch1_mute)
    else $error("volume code 255 not at +27 dB");

  a_trim_span_map: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_GAIN_TRIM && reg_wdata == 8'h00
    |-> ##2 ch1_trim_tenth_db == 5'h18)
    else $error("trim code zero not at -0.8 dB");

  a_trim_unity_reset: assert property (
    $rose(rst_sync_q) |-> ##1 ch1_trim_tenth_db == 5'h00)
    else $error("trim not at 0 dB after reset");

  a_trim_low_zero: assert property (
    reg_rvalid && $past(reg_addr) == `ACC_OFS_CH1_GAIN_TRIM |-> reg_rdata[3:0] == 4'h0)
    else $error("trim reserved bits read nonzero");

  a_phase_zero_pass: assert property (
    mod_tick && st_q.ch1_phase_trim == 8'h00 |=> ch1_delayed_bit == $past(mod_bit))
    else $error("zero phase trim added delay");

  a_coupling_pdm_off: assert property (
    ch2_source == ACC_SRC_PDM |-> !second_channel_coupling)
    else $error("coupling applied to digital microphone input");

  a_gain_ceiling: assert property (
    second_channel_gain_code_half_db <= `ACC_GAIN_MAX_CODE)
    else $error("channel two gain above 42 dB");

  a_neg_gain_guard: assert property (
    second_channel_gain_code_negative |-> (ch2_impedance == ACC_IMP_10K || ch2_impedance == ACC_IMP_20K)
                          && second_channel_gain_code_half_db <= `ACC_GAIN_NEG_MAX_CODE)
    else $error("negative gain outside its allowed range");

  a_read_latency: assert property (
    reg_rd_en && reg_addr == `ACC_OFS_SECOND_CHANNEL_GAIN_CODE_SETTING |=> reg_rvalid
    && reg_rdata == st_q.second_channel_gain_code_setting)
    else $error("gain register readback wrong");

  a_vol_write_lands: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME |=> st_q.ch1_volume == $past(reg_wdata))
    else $error("volume write did not land");

  a_mute_clear: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata != 8'h00 |-> ##2 !ch1_mute)
    else $error("nonzero volume code left channel muted");

  a_vol_half_step: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'h02
    |-> ##2 ch1_volume_half_db == 9'h139)
    else $error("volume code two not at -99.5 dB");

  a_vol_above_unity: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'hca
    |-> ##2 ch1_volume_half_db == 9'h001)
    else $error("volume code 202 not at +0.5 dB");

  a_vol_below_top: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'hfe
    |-> ##2 ch1_volume_half_db == 9'h035)
    else $error("volume code 254 not at +26.5 dB");

  a_trim_top_map: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_GAIN_TRIM && reg_wdata == 8'hf0
    |-> ##2 ch1_trim_tenth_db == 5'h07)
    else $error("trim code 15 not at +0.7 dB");

  a_type_follows_write: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH2_INPUT_SETUP
    |-> ##2 ch2_line_input == $past(reg_wdata[`ACC_IN_TYPE_BIT], 2))
    else $error("input type does not follow its bit");

  a_source_follows_write: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH2_INPUT_SETUP
    |-> ##2 ch2_source == $past(reg_wdata[`ACC_IN_SRC_MSB:`ACC_IN_SRC_LSB], 2))
    else $error("source select does not follow its field");

  a_reserved_flagged: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH2_INPUT_SETUP |-> ##2 ch2_setup_reserved ==
    ($past(reg_wdata[`ACC_IN_SRC_MSB:`ACC_IN_SRC_LSB], 2) == ACC_SRC_RSVD ||
     $past(reg_wdata[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB], 2) == ACC_IMP_RSVD))
    else $error("reserved source or impedance code not flagged");

  a_coupling_analog: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH2_INPUT_SETUP &&
    reg_wdata[`ACC_IN_SRC_MSB:`ACC_IN_SRC_LSB] != ACC_SRC_PDM
    |-> ##2 second_channel_coupling == $past(reg_wdata[`ACC_IN_COUPLE_BIT], 2))
    else $error("analog coupling does not follow its bit");

  a_imp_follows_write: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH2_INPUT_SETUP
    |-> ##2 ch2_impedance == $past(reg_wdata[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB], 2))
    else $error("impedance does not follow its field");

  a_agc_follows_write: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_CH2_INPUT_SETUP
    |-> ##2 ch2_agc_enable == $past(reg_wdata[`ACC_IN_AGC_BIT], 2))
    else $error("automatic gain enable does not follow its bit");

  a_gain_reset_zero: assert property (
    $rose(rst_sync_q) |-> st_q.second_channel_gain_code_setting == `ACC_RST_SECOND_CHANNEL_GAIN_CODE_SETTING)
    else $error("gain register left reset nonzero");

  a_gain_code_map: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_SECOND_CHANNEL_GAIN_CODE_SETTING && !reg_wdata[`ACC_GAIN_NEG_BIT] &&
    reg_wdata[`ACC_GAIN_MSB:`ACC_GAIN_LSB] <= `ACC_GAIN_MAX_CODE
    |-> ##2 second_channel_gain_code_half_db == $past(reg_wdata[`ACC_GAIN_MSB:`ACC_GAIN_LSB], 2)
    && !second_channel_gain_code_negative)
    else $error("channel two gain code not applied");

  a_neg_gain_applied: assert property (
    reg_wr_en && reg_addr == `ACC_OFS_SECOND_CHANNEL_GAIN_CODE_SETTING && reg_wdata[`ACC_GAIN_NEG_BIT] &&
    (st_q.ch2_input_setup[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB] == ACC_IMP_10K ||
     st_q.ch2_input_setup[`ACC_IN_IMP_MSB:`ACC_IN_IMP_LSB] == ACC_IMP_20K)
    |-> ##2 second_channel_gain_code_negative)
    else $error("negative gain refused at a legal impedance");

  c_mute_write: cover property (
    reg_wr_en && reg_addr == `ACC_OFS_CH1_VOLUME && reg_wdata == 8'h00 ##2 ch1_mute);
  c_pdm_select: cover property (ch2_source == ACC_SRC_PDM && ch2_agc_enable);
  c_neg_gain: cover property (second_channel_gain_code_negative && ch2_impedance == ACC_IMP_20K);
  c_phase_delay: cover property (mod_tick && st_q.ch1_phase_trim == 8'hff);
  c_gain_clamp: cover property (second_channel_gain_code_half_db == `ACC_GAIN_MAX_CODE && !second_channel_gain_code_negative);

endmodule : acc_bank

// ===== dv/acc_host.sv
// host model: drives the register port of the channel configuration bank
// assumes calls only after the bank's reset release, one access at a time
module acc_host (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // pin mux for analog or pdm sources is set up elsewhere by software
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == 8'h3f) ? 8'hf0 : (a == 8'h41) ? 8'hfd : 8'hff;
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d & m;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    // stale data is not left on the bus once released
    reg_wdata <= ~(d & m);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    // the answer stands one cycle; take it at the edge that samples it
    @(posedge sys_clk);
    d = reg_rdata;
    v = reg_rvalid;
  endtask : rd
endmodule : acc_host

// ===== dv/test_adc_channel_config_regs.sv
// self-checking bench of the channel configuration bank
// assumes acc_pkg and the bank are compiled first; host model drives the port
module test_adc_channel_config_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic         sys_clk, reset_n, mod_tick, mod_bit, go, wr_en, rd_en, rvalid, dbit;
  logic [7:0]   addr, wdata, rdata, phase;
  logic         mute, line, dc, automatic_gain_control, gneg, rsv;
  logic [8:0]   vhd;
  logic [4:0]   tenth;
  logic [1:0]   src, imp;
  logic [6:0]   ghd;
  logic [15:0]  lfsr_q, mod_q;
  logic [255:0] hist;
  logic [7:0]   sh [0:4];
  int           mismatches, comparisons, cycles, ticks, stable;

  acc_host host (.sys_clk(sys_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));

  acc_bank dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .mod_tick(mod_tick), .mod_bit(mod_bit), .ch1_delayed_bit(dbit), .ch1_mute(mute),
    .ch1_volume_half_db(vhd), .ch1_trim_tenth_db(tenth), .ch1_phase_cycles(phase),
    .ch2_line_input(line), .ch2_source(src), .second_channel_coupling(dc), .ch2_impedance(imp),
    .ch2_agc_enable(automatic_gain_control), .second_channel_gain_code_half_db(ghd), .second_channel_gain_code_negative(gneg),
    .ch2_setup_reserved(rsv));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // negative gain only counts at 10k or 20k, and is then limited to -11 dB
  function automatic logic [7:0] exp_gain(input logic [7:0] g, input logic [7:0] s);
    logic       neg;
    logic [6:0] lim;
    neg = g[0] && (s[3:2] == 2'h1 || s[3:2] == 2'h2);
    lim = neg ? 7'h16 : 7'h54;
    return {neg, (g[7:1] > lim) ? lim : g[7:1]};
  endfunction : exp_gain

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  task automatic check_all();
    logic [7:0] i;
    i = sh[3];
    check("mute", mute, sh[0] == 8'h00);
    check("volume", vhd, {1'b0, sh[0]} - 9'd201);
    check("trim", tenth, 5'({1'b0, sh[1][7:4]} - 5'd8));
    check("phase", phase, sh[2]);
    check("type", line, i[7]);
    check("source", src, i[6:5]);
    check("coupling", dc, i[4] && i[6:5] != 2'h2);
    check("impedance", imp, i[3:2]);
    check("agc", automatic_gain_control, i[0]);
    check("reserved", rsv, i[6:5] == 2'h3 || i[3:2] == 2'h3);
    check("gain", {gneg, ghd}, exp_gain(sh[4], i));
  endtask : check_all

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] r;
    logic       v;
    logic       mapped;
    mapped = a >= 8'h3e && a <= 8'h42;
    host.rd(a, r, v);
    check("rvalid", v, 1'b1);
    check("rdata", r, mapped ? sh[a - 8'h3e] : 8'h00);
  endtask : rd_chk

  task automatic access(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a >= 8'h3e && a <= 8'h42)
      sh[a - 8'h3e] = d & ((a == 8'h3f) ? 8'hf0 : (a == 8'h41) ? 8'hfd : 8'hff);
    if (a == 8'h40)
      stable = 0;
    rd_chk(a);
    check_all();
  endtask : access

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    mod_q    <= lfsr_next(mod_q);
    mod_tick <= go & mod_q[3];
    mod_bit  <= mod_q[9];
  end

  // reference delay line; only judged once enough ticks fill it and the trim settled
  always @(posedge sys_clk) begin
    cycles++;
    stable++;
    if (cycles > 20000) begin
      mismatches++;
      conclude();
    end else if (mod_tick) begin
      hist = {hist[254:0], mod_bit};
      ticks++;
      #1;
      if (ticks > sh[2] && stable > 3) check("delay", dbit, hist[sh[2]]);
    end
  end

  initial begin
    logic [15:0] corners [0:12];
    logic [7:0] a;
    corners = '{16'h3e00, 16'h3e01, 16'h3e02, 16'h3ec9, 16'h3eca,
      16'h3efe, 16'h3eff, 16'h3f00, 16'h3ff0, 16'h3f80, 16'h4001, 16'h4000, 16'h40ff};
    reset_n = 1'b0;
    mod_tick = 1'b0;
    mod_bit = 1'b0;
    go = 1'b0;
    lfsr_q = 16'h0041;
    mod_q = 16'h0041;
    hist = '0;
    sh = '{8'hc9, 8'h80, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    go <= 1'b1;
    for (int k = 8'h3c; k <= 8'h44; k++) rd_chk(8'(k));
    check_all();
    foreach (corners[n]) access(corners[n][15:8], corners[n][7:0]);
    for (int k = 0; k < 16; k++) begin
      access(8'h41, {k[0], k[1:0], ~k[0], k[3:2], 1'b1, k[1]});
      access(8'h42, {7'h50 + 7'(k), k[1]});
    end
    repeat (150) begin
      lfsr_q = lfsr_next(lfsr_q);
      a = 8'h3c + 8'(lfsr_q[7:0] % 8'd9);
      lfsr_q = lfsr_next(lfsr_q);
      access(a, lfsr_q[15:8]);
    end
    conclude();
  end
endmodule : test_adc_channel_config_regs
